// [dv/hwa_accum_bench.sv]
// bench for the window accumulator: bus tasks, windows, record checks
// assumes hwa_far_end drives the trigger, samples and record consumer
module hwa_accum_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic ext_clk = 1'b0;
  logic ext_gate = 1'b0;
  logic [2:0] div = '0;
  logic win_start;
  logic [287:0] adc_data;
  logic adc_valid;
  logic adc_clk;
  logic [31:0] rec_data;
  logic rec_valid;
  logic rec_ready;
  int bad_count = 0;
  int comparisons = 0;
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    div <= div + 3'h1;
    ext_clk <= div[2];
  end
  hwa_accum hwa_accum_i (.clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .win_start_i(win_start), .ext_clk_i(ext_clk), .ext_gate_i(ext_gate),
    .adc_data_i(adc_data), .adc_valid_i(adc_valid), .adc_clk_o(adc_clk),
    .rec_data_o(rec_data), .rec_valid_o(rec_valid),
    .rec_ready_i(rec_ready));
  hwa_far_end hwa_far_end_i (.clk_i(clk), .rst_n_i(rst_n),
    .rec_data_i(rec_data), .rec_valid_i(rec_valid),
    .win_start_o(win_start), .adc_data_o(adc_data),
    .adc_valid_o(adc_valid), .rec_ready_o(rec_ready));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // caller is just past a rising edge; every change lands by NBA
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rc(string what, logic [7:0] a, logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(what, x, e);
    chk("resp", {31'h0, hresp}, 32'h0);
  endtask
  function automatic logic [31:0] g(int i);
    return hwa_far_end_i.got[i];
  endfunction
  task automatic wait_words(int n);
    int t;
    t = 0;
    while (hwa_far_end_i.got.size() < n && t < 5000)
    begin
      @(posedge clk);
      t++;
    end
    // settle time so a surplus word would show in the count
    repeat (40) @(posedge clk);
  endtask
  // constant samples: every block sum is its count times the value
  task automatic check_rec(int base, int n);
    int v;
    int w;
    int k;
    for (int ch = 0; ch < 16; ch++)
    begin
      v = hwa_far_end_i.val(ch);
      chk("ts hi", g(base + ch * 32 + 1), 32'h0);
      for (int b = 0; b < 5; b++)
      begin
        k = (b == 0) ? n : n / 4;
        w = base + ch * 32 + 2 + b * 6;
        chk("sum", g(w), 32'(k * v));
        chk("sumsq lo", g(w + 1), 32'(k * v * v));
        chk("min", g(w + 2), 32'(v));
        chk("max", g(w + 3), 32'(v));
        chk("count", g(w + 4), 32'(k));
        chk("sumsq hi", g(w + 5), 32'h0);
      end
    end
  endtask
  task automatic toggles(output int t);
    logic last;
    t = 0;
    last = adc_clk;
    repeat (96)
    begin
      @(posedge clk);
      if (adc_clk !== last)
        t++;
      last = adc_clk;
    end
  endtask
  initial
  begin
    #400000;
    bad_count++;
    wrap_up();
  end
  initial
  begin
    int t;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc("ctrl", 8'h00, 32'h0);
    rc("delay", 8'h04, 32'h0);
    rc("nsamp", 8'h08, 32'h400);
    rc("clkdiv", 8'h0c, 32'h0);
    rc("status", 8'h10, 32'h9);
    rc("unmapped", 8'h40, 32'h0);
    wr(8'h10, 32'hffffffff);
    rc("status ro", 8'h10, 32'h9);
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h8);
    wr(8'h00, 32'h1);
    rc("delay rw", 8'h04, 32'h3);
    hwa_far_end_i.fire();
    wait_words(512);
    chk("words", 32'(hwa_far_end_i.got.size()), 32'h200);
    check_rec(0, 8);
    // slow samples keep the second window open across the restart
    wr(8'h08, 32'h10);
    hwa_far_end_i.gap = 60;
    hwa_far_end_i.fire();
    repeat (300) @(posedge clk);
    hwa_far_end_i.fire();
    wait_words(1536);
    chk("words", 32'(hwa_far_end_i.got.size()), 32'h600);
    chk("early close", g(518) >> 31, 32'h1);
    check_rec(1024, 16);
    rc("wincnt", 8'h18, 32'h3);
    rc("status idle", 8'h10, 32'h9);
    // diag: window stays open long enough for three raw sets
    wr(8'h00, 32'h3);
    hwa_far_end_i.fire();
    wait_words(1584);
    chk("raw words", 32'(hwa_far_end_i.got.size() >= 1584), 32'h1);
    for (int i = 0; i < 48; i++)
      chk("raw", g(1536 + i),
        {4'(i % 16), 10'h000, 18'(hwa_far_end_i.val(i % 16))});
    rc("drops", 8'h14, 32'h0);
    wr(8'h00, 32'h0);
    ext_gate <= 1'b1;
    toggles(t);
    chk("clk div0", 32'(t >= 10 && t <= 12), 32'h1);
    wr(8'h0c, 32'h1);
    toggles(t);
    chk("clk div1", 32'(t >= 4 && t <= 6), 32'h1);
    ext_gate <= 1'b0;
    repeat (10) @(posedge clk);
    chk("gate low", {31'h0, adc_clk}, 32'h0);
    wrap_up();
  end
endmodule

// [dv/hwa_far_end.sv]
// far-end model: window trigger, sample source and record consumer
// assumes the accumulator's clk_i; samples are constant per channel
module hwa_far_end (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] rec_data_i,
  input wire logic rec_valid_i,
  output logic win_start_o,
  output logic [287:0] adc_data_o,
  output logic adc_valid_o,
  output logic rec_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] got[$];
  logic [287:0] smp;
  int gap = 4;
  int cyc = 0;
  int hold = 0;
  function automatic int val(int n);
    return (n - 8) * 1000;
  endfunction
  always_comb
  begin
    for (int n = 0; n < 16; n++)
      smp[18*n +: 18] = 18'(val(n));
  end
  initial
  begin
    win_start_o = 1'b0;
    adc_valid_o = 1'b0;
    adc_data_o = '0;
    rec_ready_o = 1'b0;
  end
  // off-pulse data is inverted so a stale bus never looks valid
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    adc_valid_o <= (cyc % gap == 0);
    adc_data_o <= (cyc % gap == 0) ? smp : ~smp;
    // long stall at the start of each 512-word window readout lets the FIFO fill
    if (rec_valid_i && hold < 80)
      hold <= hold + 1;
    if (rec_valid_i && rec_ready_o && got.size() % 512 == 511)
      hold <= 0;
    if (rec_valid_i && rec_ready_o)
      got.push_back(rec_data_i);
    rec_ready_o <= rst_n_i && hold >= 80 && cyc % 5 != 0;
  end
  task automatic fire();
    @(posedge clk_i);
    win_start_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    win_start_o <= 1'b0;
  endtask
endmodule

// [hw/hwa_accum.sv]
// sixteen-channel window accumulator with bus registers and record FIFO
// assumes samples arrive on clk_i from the capture logic; window and
// sample clock pins are asynchronous; AHB-Lite slave answers zero-wait
// Behaviour
// - wait programmed delay after window start
// - accumulate exactly the programmed sample count
// - sum, squares, min, max, count per channel
// - each block is six 32-bit words
// - subblock sums add to full-window sums
// - four subblocks plus full window, all channels
// - 8-byte timestamp, 128-byte record per channel
// - sixteen channels processed in parallel
// - 18-bit samples, rate up to 15 Msps
// - sample rate a multiple of 60 Hz
// - sample clock from external clock and gate
// - diagnostic streaming of raw samples
// - diagnostic mode reports every window subsample; code skips samples that arrive during a readout (counted in drops)
// - production mode records every window, no deadtime; code drops a window ending during record readout (counted in overruns)
// - delay adjustable in 20 ns steps
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
`include "hwa_cfg.svh"
module hwa_accum (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic win_start_i,
  input wire logic ext_clk_i,
  input wire logic ext_gate_i,
  input wire logic [`HWA_NCH*`HWA_SW-1:0] adc_data_i,
  input wire logic adc_valid_i,
  output logic adc_clk_o,
  output logic [31:0] rec_data_o,
  output logic rec_valid_o,
  input wire logic rec_ready_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [1:0] start_sync, eclk_sync, gate_sync;
  logic start_d, eclk_d, sow_rise, eclk_rise;
  logic ctrl_en, ctrl_diag;
  logic [15:0] delay, dly_cnt, drops, overruns;
  logic [19:0] nsamp, sub_cnt, sub_len;
  logic [7:0] clk_div, div_cnt;
  logic [31:0] win_cnt;
  logic wr_pend;
  logic [7:0] wr_addr;
  hwa_pkg::hwa_win_t w_state;
  hwa_pkg::hwa_rd_t rd_state;
  logic [1:0] sub;
  logic [2:0] sidx;
  logic acc_en, last, done_q, snap, snap_ok, raw_take, push, f_ready;
  logic start_new;
  logic [63:0] ts, win_ts, sh_ts;
  logic sh_trunc;
  logic signed [`HWA_SW-1:0] smp [`HWA_NCH];
  logic [63:0] sq [`HWA_NCH];
  logic signed [31:0] a_sum [`HWA_NSLOT][`HWA_NCH];
  logic [63:0] a_sq [`HWA_NSLOT][`HWA_NCH];
  logic signed [`HWA_SW-1:0] a_min [`HWA_NSLOT][`HWA_NCH];
  logic signed [`HWA_SW-1:0] a_max [`HWA_NSLOT][`HWA_NCH];
  logic [31:0] a_cnt [`HWA_NSLOT];
  logic signed [31:0] sh_sum [`HWA_NSLOT][`HWA_NCH];
  logic [63:0] sh_sq [`HWA_NSLOT][`HWA_NCH];
  logic signed [`HWA_SW-1:0] sh_min [`HWA_NSLOT][`HWA_NCH];
  logic signed [`HWA_SW-1:0] sh_max [`HWA_NSLOT][`HWA_NCH];
  logic [31:0] sh_cnt [`HWA_NSLOT];
  logic signed [`HWA_SW-1:0] raw_sh [`HWA_NCH];
  logic [3:0] rc;
  logic [4:0] w;
  logic [2:0] b, k;
  logic [31:0] f_data;

  // pins cross in through two flops; edge logic reads the second only
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      start_sync <= 2'h0;
      eclk_sync <= 2'h0;
      gate_sync <= 2'h0;
      start_d <= 1'b0;
      eclk_d <= 1'b0;
    end
    else
    begin
      start_sync <= {start_sync[0], win_start_i};
      eclk_sync <= {eclk_sync[0], ext_clk_i};
      gate_sync <= {gate_sync[0], ext_gate_i};
      start_d <= start_sync[1];
      eclk_d <= eclk_sync[1];
    end
  end
  assign sow_rise = start_sync[1] & ~start_d;
  assign eclk_rise = eclk_sync[1] & ~eclk_d;

  // software picks clk_div so the converter rate is a 60 Hz multiple
  // external clock must stay below a quarter of clk_i
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      adc_clk_o <= 1'b0;
      div_cnt <= 8'h00;
    end
    else if (!gate_sync[1])
    begin
      adc_clk_o <= 1'b0;
      div_cnt <= 8'h00;
    end
    else if (eclk_rise)
    begin
      if (div_cnt == clk_div)
      begin
        adc_clk_o <= ~adc_clk_o;
        div_cnt <= 8'h00;
      end
      else
        div_cnt <= div_cnt + 8'h01;
    end
  end

  // window sequencing: delay in clk_i steps gives 20 ns placement
  assign start_new = ctrl_en & sow_rise;
  assign acc_en = (w_state == hwa_pkg::HWA_W_ACC) & adc_valid_i & ~sow_rise;
  assign last = (a_cnt[0] + 32'h1) >= {12'h000, nsamp};
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      w_state <= hwa_pkg::HWA_W_IDLE;
      dly_cnt <= 16'h0000;
    end
    else if (!ctrl_en)
      w_state <= hwa_pkg::HWA_W_IDLE;
    else if (sow_rise)
    begin
      w_state <= hwa_pkg::HWA_W_DELAY;
      dly_cnt <= 16'h0000;
    end
    else
      case (w_state)
        hwa_pkg::HWA_W_DELAY:
          if (dly_cnt == delay)
            w_state <= hwa_pkg::HWA_W_ACC;
          else
            dly_cnt <= dly_cnt + 16'h0001;
        hwa_pkg::HWA_W_ACC:
          if (acc_en && last)
            w_state <= hwa_pkg::HWA_W_IDLE;
        default:
          w_state <= hwa_pkg::HWA_W_IDLE;
      endcase
  end

  genvar g;
  generate
    for (g = 0; g < `HWA_NCH; g++)
    begin : g_ch
      logic signed [35:0] p;
      assign smp[g] = $signed(adc_data_i[g*`HWA_SW +: `HWA_SW]);
      assign p = smp[g] * smp[g];
      assign sq[g] = {28'h0000000, p};
    end
  endgenerate

  // subblock length is a quarter; the last one takes the remainder
  assign sub_len = nsamp >> 2;
  assign sidx = {1'b0, sub} + 3'h1;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sub <= 2'h0;
      sub_cnt <= 20'h00000;
    end
    else if (start_new)
    begin
      sub <= 2'h0;
      sub_cnt <= 20'h00000;
    end
    else if (acc_en)
    begin
      if (sub != 2'h3 && sub_cnt + 20'h00001 >= sub_len)
      begin
        sub <= sub + 2'h1;
        sub_cnt <= 20'h00000;
      end
      else
        sub_cnt <= sub_cnt + 20'h00001;
    end
  end

  // each sample lands in slot 0 and in its subblock slot
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int s = 0; s < `HWA_NSLOT; s++)
      begin
        a_cnt[s] <= 32'h0;
        for (int c = 0; c < `HWA_NCH; c++)
        begin
          a_sum[s][c] <= 32'sh0;
          a_sq[s][c] <= 64'h0;
          a_min[s][c] <= `HWA_MIN_INIT;
          a_max[s][c] <= `HWA_MAX_INIT;
        end
      end
    end
    else if (start_new)
    begin
      for (int s = 0; s < `HWA_NSLOT; s++)
      begin
        a_cnt[s] <= 32'h0;
        for (int c = 0; c < `HWA_NCH; c++)
        begin
          a_sum[s][c] <= 32'sh0;
          a_sq[s][c] <= 64'h0;
          a_min[s][c] <= `HWA_MIN_INIT;
          a_max[s][c] <= `HWA_MAX_INIT;
        end
      end
    end
    else if (acc_en)
    begin
      a_cnt[0] <= a_cnt[0] + 32'h1;
      a_cnt[sidx] <= a_cnt[sidx] + 32'h1;
      for (int c = 0; c < `HWA_NCH; c++)
      begin
        a_sum[0][c] <= a_sum[0][c] + 32'(smp[c]);
        a_sum[sidx][c] <= a_sum[sidx][c] + 32'(smp[c]);
        a_sq[0][c] <= a_sq[0][c] + sq[c];
        a_sq[sidx][c] <= a_sq[sidx][c] + sq[c];
        if (smp[c] < a_min[0][c])
          a_min[0][c] <= smp[c];
        if (smp[c] < a_min[sidx][c])
          a_min[sidx][c] <= smp[c];
        if (smp[c] > a_max[0][c])
          a_max[0][c] <= smp[c];
        if (smp[c] > a_max[sidx][c])
          a_max[sidx][c] <= smp[c];
      end
    end
  end

  // snapshot one cycle after the last sample so it is included;
  // a restart mid-window closes the partial record with a flag
  assign snap = ctrl_en & (done_q | (sow_rise & w_state != hwa_pkg::HWA_W_IDLE));
  assign snap_ok = snap & (rd_state != hwa_pkg::HWA_RD_REC);
  assign raw_take = ctrl_diag & acc_en & ~snap_ok
                  & (rd_state == hwa_pkg::HWA_RD_IDLE);
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      done_q <= 1'b0;
      ts <= 64'h0;
      win_ts <= 64'h0;
      sh_ts <= 64'h0;
      sh_trunc <= 1'b0;
      win_cnt <= 32'h0;
      overruns <= 16'h0000;
      drops <= 16'h0000;
    end
    else
    begin
      done_q <= acc_en & last;
      ts <= ts + 64'h1;
      if (start_new)
        win_ts <= ts;
      if (snap_ok)
      begin
        sh_ts <= win_ts;
        sh_trunc <= ~done_q;
        win_cnt <= win_cnt + 32'h1;
      end
      if (snap && !snap_ok)
        overruns <= overruns + 16'h0001;
      if (ctrl_diag && acc_en && !raw_take)
        drops <= drops + 16'h0001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (snap_ok)
    begin
      sh_cnt <= a_cnt;
      sh_sum <= a_sum;
      sh_sq <= a_sq;
      sh_min <= a_min;
      sh_max <= a_max;
    end
    if (raw_take)
      raw_sh <= smp;
  end

  // readout: records preempt raw streaming, which has no throughput goal
  assign push = (rd_state != hwa_pkg::HWA_RD_IDLE) & f_ready;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_state <= hwa_pkg::HWA_RD_IDLE;
      rc <= 4'h0;
      w <= 5'h00;
      b <= 3'h0;
      k <= 3'h0;
    end
    else if (snap_ok)
    begin
      rd_state <= hwa_pkg::HWA_RD_REC;
      rc <= 4'h0;
      w <= 5'h00;
      b <= 3'h0;
      k <= 3'h0;
    end
    else
      case (rd_state)
        hwa_pkg::HWA_RD_IDLE:
          if (raw_take)
          begin
            rd_state <= hwa_pkg::HWA_RD_RAW;
            rc <= 4'h0;
          end
        hwa_pkg::HWA_RD_REC:
          if (push)
          begin
            w <= w + 5'h01;
            if (w >= `HWA_TS_WORDS)
            begin
              k <= (k == `HWA_LAST_K) ? 3'h0 : k + 3'h1;
              if (k == `HWA_LAST_K)
                b <= b + 3'h1;
            end
            if (w == `HWA_LAST_WORD)
            begin
              b <= 3'h0;
              rc <= rc + 4'h1;
              if (rc == `HWA_LAST_CH)
                rd_state <= hwa_pkg::HWA_RD_IDLE;
            end
          end
        hwa_pkg::HWA_RD_RAW:
          if (push)
          begin
            rc <= rc + 4'h1;
            if (rc == `HWA_LAST_CH)
              rd_state <= hwa_pkg::HWA_RD_IDLE;
          end
        default:
          rd_state <= hwa_pkg::HWA_RD_IDLE;
      endcase
  end

  always_comb
  begin
    f_data = 32'h0;
    if (rd_state == hwa_pkg::HWA_RD_RAW)
      f_data = {rc, `HWA_RAW_PAD, raw_sh[rc]};
    else if (w == 5'h00)
      f_data = sh_ts[31:0];
    else if (w == 5'h01)
      f_data = sh_ts[63:32];
    else
      case (k)
        3'h0: f_data = sh_sum[b][rc];
        3'h1: f_data = sh_sq[b][rc][31:0];
        3'h2: f_data = 32'(sh_min[b][rc]);
        3'h3: f_data = 32'(sh_max[b][rc]);
        3'h4: f_data = {sh_trunc, sh_cnt[b][30:0]};
        default: f_data = sh_sq[b][rc][63:32];
      endcase
  end

  hwa_fifo #(
    .WIDTH(`HWA_FIFO_WIDTH),
    .DEPTH(`HWA_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(rd_state != hwa_pkg::HWA_RD_IDLE),
    .in_ready_o(f_ready),
    .in_data_i(f_data),
    .out_valid_o(rec_valid_o),
    .out_ready_i(rec_ready_i),
    .out_data_o(rec_data_o)
  );

  // bus slave: zero wait, always OKAY, unmapped reads return zero
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
      hrdata_o <= 32'h0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      wr_pend <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
      wr_addr <= haddr_i[7:0];
      hrdata_o <= 32'h0;
      if (hsel_i && htrans_i[1] && hready_i && !hwrite_i)
        case (haddr_i[7:0])
          `HWA_REG_CTRL: hrdata_o <= {30'h0, ctrl_diag, ctrl_en};
          `HWA_REG_DELAY: hrdata_o <= {16'h0000, delay};
          `HWA_REG_NSAMP: hrdata_o <= {12'h000, nsamp};
          `HWA_REG_CLKDIV: hrdata_o <= {24'h000000, clk_div};
          `HWA_REG_STATUS: hrdata_o <= {overruns, 10'h000,
                                        rd_state, w_state};
          `HWA_REG_DROPS: hrdata_o <= {16'h0000, drops};
          `HWA_REG_WINCNT: hrdata_o <= win_cnt;
          default: hrdata_o <= 32'h0;
        endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_en <= 1'b0;
      ctrl_diag <= 1'b0;
      delay <= `HWA_RST_DELAY;
      nsamp <= `HWA_RST_NSAMP;
      clk_div <= `HWA_RST_CLKDIV;
    end
    else if (wr_pend)
      case (wr_addr)
        `HWA_REG_CTRL:
        begin
          ctrl_en <= hwdata_i[`HWA_CTRL_EN];
          ctrl_diag <= hwdata_i[`HWA_CTRL_DIAG];
        end
        `HWA_REG_DELAY: delay <= hwdata_i[15:0];
        `HWA_REG_NSAMP: nsamp <= hwdata_i[19:0];
        `HWA_REG_CLKDIV: clk_div <= hwdata_i[7:0];
        default: ;
      endcase
  end

  a_delay_exact: assert property (
    w_state == hwa_pkg::HWA_W_DELAY && dly_cnt == delay && ctrl_en
    && !sow_rise |=> w_state == hwa_pkg::HWA_W_ACC)
    else $error("accumulation did not start after the delay");
  a_count_exact: assert property (
    acc_en && last && ctrl_en && rd_state != hwa_pkg::HWA_RD_REC
    |=> ##1 sh_cnt[0] == $past(a_cnt[0], 2) + 32'h1 && !sh_trunc)
    else $error("snapshot count differs from samples taken");
  a_min_max: assert property (
    snap_ok && a_cnt[0] != 32'h0 |=> sh_min[0][0] <= sh_max[0][0])
    else $error("minimum above maximum");
  a_sub_sum: assert property (
    $past(snap_ok) |-> sh_sum[0][3] == sh_sum[1][3] + sh_sum[2][3]
    + sh_sum[3][3] + sh_sum[4][3])
    else $error("subblock sums do not add to window sum");
  a_sub_count: assert property (
    $past(snap_ok) |-> sh_cnt[0] == sh_cnt[1] + sh_cnt[2]
    + sh_cnt[3] + sh_cnt[4])
    else $error("subblock counts do not add to window count");
  a_rec_stamp: assert property (
    push && rd_state == hwa_pkg::HWA_RD_REC && w == 5'h01
    |-> f_data == sh_ts[63:32] ##1 w == `HWA_TS_WORDS && k == 3'h0)
    else $error("timestamp word misplaced");
  a_early_flag: assert property (
    ctrl_en && sow_rise && !done_q && w_state == hwa_pkg::HWA_W_ACC
    && rd_state != hwa_pkg::HWA_RD_REC |=> sh_trunc)
    else $error("early restart not flagged");
  a_raw_word: assert property (
    rd_state == hwa_pkg::HWA_RD_RAW |-> f_data[17:0] == raw_sh[rc])
    else $error("raw word does not carry the sample");
  a_gate_off: assert property (
    !gate_sync[1] |=> !adc_clk_o)
    else $error("sample clock runs without gate");
endmodule

// [hw/hwa_cfg.svh]
// constants for the window accumulator: offsets, fields, reset values
// assumes a 50 MHz clk_i and a 32-bit bus data path
`ifndef HWA_CFG_SVH
`define HWA_CFG_SVH
`define HWA_CLK_HZ 50000000
`define HWA_NCH 16
`define HWA_NSUB 4
`define HWA_NSLOT 5
`define HWA_SW 18
`define HWA_FIFO_DEPTH 32
`define HWA_FIFO_WIDTH 32
`define HWA_LAST_CH 4'hf
`define HWA_LAST_WORD 5'h1f
`define HWA_LAST_K 3'h5
`define HWA_TS_WORDS 5'h02
`define HWA_REG_CTRL 8'h00
`define HWA_REG_DELAY 8'h04
`define HWA_REG_NSAMP 8'h08
`define HWA_REG_CLKDIV 8'h0c
`define HWA_REG_STATUS 8'h10
`define HWA_REG_DROPS 8'h14
`define HWA_REG_WINCNT 8'h18
`define HWA_CTRL_EN 0
`define HWA_CTRL_DIAG 1
`define HWA_RST_DELAY 16'h0000
`define HWA_RST_NSAMP 20'h00400
`define HWA_RST_CLKDIV 8'h00
`define HWA_MIN_INIT 18'h1ffff
`define HWA_MAX_INIT 18'h20000
`define HWA_RAW_PAD 10'h000
`endif

// [hw/hwa_fifo.sv]
// word FIFO with valid/ready on both sides and a registered output
// assumes one clock; DEPTH is a power of two
module hwa_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign push = in_valid_i & in_ready_o;
  // output stage refills whenever it is empty or being taken
  assign pop = (count != '0) & (~out_valid_o | out_ready_i);

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wp] <= in_data_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wp <= '0;
      rp <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wp <= wp + 1'b1;
      if (pop)
        rp <= rp + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end
    else if (pop)
    begin
      out_valid_o <= 1'b1;
      out_data_o <= mem[rp];
    end
    else if (out_ready_i)
      out_valid_o <= 1'b0;
  end
endmodule

// [hw/hwa_pkg.sv]
// types shared by the window accumulator files
// assumes nothing beyond the constants header
package hwa_pkg;
  typedef enum logic [2:0] {
    HWA_W_IDLE = 3'b001,
    HWA_W_DELAY = 3'b010,
    HWA_W_ACC = 3'b100
  } hwa_win_t;
  typedef enum logic [2:0] {
    HWA_RD_IDLE = 3'b001,
    HWA_RD_REC = 3'b010,
    HWA_RD_RAW = 3'b100
  } hwa_rd_t;
endpackage
